// File: rtl/ipl_pkg.sv
// Constants and types shared by the palette lookup pipeline.
package ipl_pkg;
    localparam int IPL_PIX_W = 8;
    localparam int IPL_OVL_W = 4;
    localparam int IPL_CH1_AW = 12;
    localparam int IPL_DUAL_AW = 16;
    localparam int IPL_RGB_W = 24;
    localparam int IPL_SLICE_W = 4;
    localparam int IPL_CH1_SLICES = 6;
    localparam int IPL_RED_LSB = 0;
    localparam int IPL_GRN_LSB = 8;
    localparam int IPL_BLU_LSB = 16;
    localparam int IPL_MASK_A_LSB = 0;
    localparam int IPL_MASK_B_LSB = 8;
    localparam int IPL_FIFO_DEPTH = 2;
    localparam logic [15:0] IPL_DUAL_MASK_RST = 16'h0000;
    localparam logic [7:0] IPL_BLANK_LEVEL = 8'h00;

    // Source chosen by the prioritizer for the dual output, Gray ordered.
    typedef enum logic [1:0] {
        IPL_SRC_GFX = 2'h0,
        IPL_SRC_IMG_A = 2'h1,
        IPL_SRC_IMG_B = 2'h3,
        IPL_SRC_DUAL = 2'h2
    } ipl_src_t;
endpackage : ipl_pkg

// File: rtl/ipl_palette_pipe.sv
// Pixel colour lookup path: mask gates, palettes, output multiplexers and DAC input stage.
`timescale 1ns/1ps
module ipl_palette_pipe
    import ipl_pkg::*;
#(
    parameter int CH1_AW = IPL_CH1_AW,
    parameter int DUAL_AW = IPL_DUAL_AW
) (
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic i_clk_en,
    input wire logic i_pix_valid,
    output logic o_pix_ready,
    input wire logic [IPL_PIX_W-1:0] i_img_a_pixel_bits,
    input wire logic [IPL_PIX_W-1:0] i_img_b_pixel_bits,
    input wire logic i_cursor_bit_a,
    input wire logic i_cursor_bit_b,
    input wire logic i_char_pixel_bit,
    input wire logic i_blink_bit,
    input wire logic [IPL_PIX_W-1:0] i_ch1_data_mask,
    input wire logic [IPL_OVL_W-1:0] i_ch1_overlay_mask,
    input wire logic i_panel_blank_ch1,
    input wire logic i_panel_blank_ch2,
    input wire logic i_visible_line_gate_n,
    input wire logic [DUAL_AW-1:0] i_host_palette_addr,
    input wire logic [IPL_RGB_W-1:0] i_host_palette_data,
    input wire logic i_ch1_palette_we_n,
    input wire logic i_dual_palette_we_n,
    input wire logic i_dual_mask_we_n,
    input wire logic [IPL_RGB_W-1:0] i_gfx_rgb,
    input wire logic [IPL_RGB_W-1:0] i_img_b_rgb,
    input wire logic i_graphics_reg_clear_n,
    input wire logic i_ch1_gfx_oe,
    input wire logic [1:0] i_dual_src_sel,
    input wire logic i_sync_n,
    input wire logic i_blank_n,
    output logic [7:0] o_ch1_red,
    output logic [7:0] o_ch1_green,
    output logic [7:0] o_ch1_blue,
    output logic o_ch1_sync_n,
    output logic o_sync_current_on,
    output logic o_dual_valid,
    input wire logic i_dual_ready,
    output logic [IPL_RGB_W-1:0] o_dual_rgb
);
    logic visible;
    logic adv;
    logic pb1_r;
    logic pb2_r;
    logic [15:0] dual_mask_r;
    logic [CH1_AW-1:0] ch1_addr_r;
    logic [DUAL_AW-1:0] dual_addr_r;
    logic [CH1_AW-1:0] ch1_rd_addr;
    logic [DUAL_AW-1:0] dual_rd_addr;
    logic [IPL_RGB_W-1:0] ch1_rd_r;
    logic [IPL_RGB_W-1:0] dual_rd_r;
    logic [IPL_RGB_W-1:0] ch1_img_r;
    logic [IPL_RGB_W-1:0] ch1_gfx_r;
    logic [IPL_RGB_W-1:0] dm_gfx_r;
    logic [IPL_RGB_W-1:0] dm_img_a_r;
    logic [IPL_RGB_W-1:0] dm_img_b_r;
    logic [IPL_RGB_W-1:0] dm_dual_r;
    logic [IPL_RGB_W-1:0] ch1_sel;
    logic [IPL_RGB_W-1:0] dual_sel;
    logic v1_r;
    logic v2_r;
    logic v3_r;
    logic [IPL_RGB_W-1:0] fifo_mem [0:IPL_FIFO_DEPTH-1];
    logic fifo_wp_r;
    logic fifo_rp_r;
    logic [1:0] fifo_cnt_r;
    logic fifo_full;
    logic push;
    logic pop;

    assign visible = ~i_visible_line_gate_n;
    assign fifo_full = (fifo_cnt_r == 2'(IPL_FIFO_DEPTH));
    // Back-pressure: stages 1 to 4 hold while the output buffer cannot take a word; the panel-blank registers still sample.
    assign adv = i_clk_en & (~fifo_full | i_dual_ready);
    assign o_pix_ready = adv;

    // Decodes a prioritizer source code into the selected registered word.
    function automatic logic [IPL_RGB_W-1:0] pick_src(input logic [1:0] sel,
            input logic [IPL_RGB_W-1:0] g, input logic [IPL_RGB_W-1:0] a,
            input logic [IPL_RGB_W-1:0] b, input logic [IPL_RGB_W-1:0] d);
        logic [IPL_RGB_W-1:0] r;
        r = g;
        case (ipl_src_t'(sel))
            IPL_SRC_GFX: r = g;
            IPL_SRC_IMG_A: r = a;
            IPL_SRC_IMG_B: r = b;
            IPL_SRC_DUAL: r = d;
            default: r = g;
        endcase
        return r;
    endfunction : pick_src

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            pb1_r <= 1'b0;
            pb2_r <= 1'b0;
        end else if (i_clk_en) begin
            pb1_r <= i_panel_blank_ch1;
            pb2_r <= i_panel_blank_ch2;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            dual_mask_r <= IPL_DUAL_MASK_RST;
        end else if (i_clk_en && !i_dual_mask_we_n) begin
            dual_mask_r <= i_host_palette_data[15:0];
        end
    end

    // Stage 1: mask gates and masked address registers.
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            ch1_addr_r <= '0;
            dual_addr_r <= '0;
            v1_r <= 1'b0;
        end else if (adv) begin
            ch1_addr_r[7:0] <= i_img_a_pixel_bits & i_ch1_data_mask & {8{pb1_r}};
            ch1_addr_r[11:8] <= {i_blink_bit, i_char_pixel_bit, i_cursor_bit_b,
                                 i_cursor_bit_a} & i_ch1_overlay_mask;
            dual_addr_r[7:0] <= i_img_a_pixel_bits & dual_mask_r[IPL_MASK_A_LSB +: 8]
                                & {8{pb1_r}};
            dual_addr_r[15:8] <= i_img_b_pixel_bits & dual_mask_r[IPL_MASK_B_LSB +: 8]
                                 & {8{pb2_r}};
            v1_r <= i_pix_valid & visible;
        end
    end

    // Only one address source drives each palette at a time.
    assign ch1_rd_addr = visible ? ch1_addr_r : i_host_palette_addr[CH1_AW-1:0];
    assign dual_rd_addr = visible ? dual_addr_r : i_host_palette_addr;

    // Stage 2: channel palette in six 4-bit slices with separate write and read data.
    genvar g;
    generate
        for (g = 0; g < IPL_CH1_SLICES; g++) begin : g_ch1_slice
            logic [IPL_SLICE_W-1:0] mem [0:(1<<CH1_AW)-1];
            always_ff @(posedge i_clk_sys) begin
                if (i_clk_en && !i_ch1_palette_we_n && !visible) begin
                    mem[ch1_rd_addr] <= i_host_palette_data[g*IPL_SLICE_W +: IPL_SLICE_W];
                end
            end
            always_ff @(posedge i_clk_sys) begin
                if (adv) begin
                    ch1_rd_r[g*IPL_SLICE_W +: IPL_SLICE_W] <= mem[ch1_rd_addr];
                end
            end
        end
    endgenerate

    logic [IPL_RGB_W-1:0] dual_mem [0:(1<<DUAL_AW)-1];
    always_ff @(posedge i_clk_sys) begin
        if (i_clk_en && !i_dual_palette_we_n && !visible) begin
            dual_mem[dual_rd_addr] <= i_host_palette_data;
        end
    end
    always_ff @(posedge i_clk_sys) begin
        if (adv) begin
            dual_rd_r <= dual_mem[dual_rd_addr];
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            v2_r <= 1'b0;
            v3_r <= 1'b0;
        end else if (adv) begin
            v2_r <= v1_r;
            v3_r <= v2_r;
        end
    end

    // Stage 3: multiplexer source registers.
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            ch1_img_r <= '0;
            dm_img_a_r <= '0;
            dm_img_b_r <= '0;
            dm_dual_r <= '0;
        end else if (adv) begin
            ch1_img_r <= ch1_rd_r;
            dm_img_a_r <= ch1_rd_r;
            dm_img_b_r <= i_img_b_rgb;
            dm_dual_r <= dual_rd_r;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_graphics_reg_clear_n) begin
        if (!i_graphics_reg_clear_n) begin
            ch1_gfx_r <= '0;
            dm_gfx_r <= '0;
        end else if (i_sys_rst) begin
            ch1_gfx_r <= '0;
            dm_gfx_r <= '0;
        end else if (adv) begin
            ch1_gfx_r <= i_gfx_rgb;
            dm_gfx_r <= i_gfx_rgb;
        end
    end

    assign ch1_sel = i_ch1_gfx_oe ? ch1_gfx_r : ch1_img_r;
    assign dual_sel = pick_src(i_dual_src_sel, dm_gfx_r, dm_img_a_r, dm_img_b_r,
                               dm_dual_r);

    // Stage 4: DAC input capture with blanking applied.
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            o_ch1_red <= IPL_BLANK_LEVEL;
            o_ch1_green <= IPL_BLANK_LEVEL;
            o_ch1_blue <= IPL_BLANK_LEVEL;
            o_ch1_sync_n <= 1'b1;
            o_sync_current_on <= 1'b1;
        end else if (adv) begin
            o_ch1_red <= i_blank_n ? ch1_sel[IPL_RED_LSB +: 8] : IPL_BLANK_LEVEL;
            o_ch1_green <= i_blank_n ? ch1_sel[IPL_GRN_LSB +: 8] : IPL_BLANK_LEVEL;
            o_ch1_blue <= i_blank_n ? ch1_sel[IPL_BLU_LSB +: 8] : IPL_BLANK_LEVEL;
            // Sync is honoured only inside blanking, since it cannot override colour.
            o_ch1_sync_n <= i_sync_n | i_blank_n;
            o_sync_current_on <= i_sync_n | i_blank_n;
        end
    end

    // Two-entry output buffer for the dual channel word.
    assign push = adv & v3_r;
    assign pop = i_clk_en & o_dual_valid & i_dual_ready;
    assign o_dual_valid = (fifo_cnt_r != 2'h0);
    assign o_dual_rgb = fifo_mem[fifo_rp_r];

    always_ff @(posedge i_clk_sys) begin
        if (push) begin
            fifo_mem[fifo_wp_r] <= dual_sel;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            fifo_wp_r <= 1'b0;
            fifo_rp_r <= 1'b0;
            fifo_cnt_r <= 2'h0;
        end else begin
            if (push) begin
                fifo_wp_r <= ~fifo_wp_r;
            end
            if (pop) begin
                fifo_rp_r <= ~fifo_rp_r;
            end
            fifo_cnt_r <= fifo_cnt_r + 2'(push) - 2'(pop);
        end
    end

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_sys_rst);

    a_ch1_data_gate: assert property (adv |=> ch1_addr_r[7:0] == ($past(i_img_a_pixel_bits)
            & $past(i_ch1_data_mask) & {8{$past(pb1_r)}}))
        else $error("channel data bits not gated by mask and panel qualifier");
    a_overlay_gate: assert property (adv |=> ch1_addr_r[11:8] == ($past(i_ch1_overlay_mask)
            & {$past(i_blink_bit), $past(i_char_pixel_bit), $past(i_cursor_bit_b),
               $past(i_cursor_bit_a)}))
        else $error("overlay bits not gated by their own mask bits");
    a_host_addr_own: assert property (!visible |-> (ch1_rd_addr == i_host_palette_addr[CH1_AW-1:0]
            && dual_rd_addr == i_host_palette_addr))
        else $error("host does not own palette address in blanking");
    a_ch1_write_read: assert property ((adv && !visible && !i_ch1_palette_we_n) ##1
            (adv && !visible && i_ch1_palette_we_n && $stable(i_host_palette_addr))
            |=> ch1_rd_r == $past(i_host_palette_data, 2))
        else $error("channel palette did not return written word");
    a_dual_write_read: assert property ((adv && !visible && !i_dual_palette_we_n) ##1
            (adv && !visible && i_dual_palette_we_n && $stable(i_host_palette_addr))
            |=> dual_rd_r == $past(i_host_palette_data, 2))
        else $error("dual palette did not return written word");
    a_dac_blanking: assert property ((adv && !i_blank_n) |=>
            (o_ch1_red == IPL_BLANK_LEVEL && o_ch1_green == IPL_BLANK_LEVEL
            && o_ch1_blue == IPL_BLANK_LEVEL && o_sync_current_on == $past(i_sync_n)))
        else $error("blank did not force blanking level");
    a_sync_current: assert property ((adv && !i_sync_n && !i_blank_n) |=> !o_sync_current_on
            ##1 (o_sync_current_on || !$past(i_sync_n) || !adv || !$past(adv)))
        else $error("sync current not switched off during sync");
    a_dual_gate: assert property (adv |=> dual_addr_r[15:8] == ($past(i_img_b_pixel_bits)
            & $past(dual_mask_r[15:8]) & {8{$past(pb2_r)}}))
        else $error("image b dual bits not gated");
    a_gfx_clear: assert property (!i_graphics_reg_clear_n |-> (ch1_gfx_r == '0
            && dm_gfx_r == '0))
        else $error("graphics registers not cleared");
    a_buffer_full: assert property (fifo_full && !i_dual_ready |-> !o_pix_ready ##1
            (o_dual_valid && $stable(o_dual_rgb)))
        else $error("full buffer advanced or lost its head word");

    c_host_load: cover property (!visible && !i_ch1_palette_we_n ##1 visible);
    c_buffer_full: cover property (fifo_full);
    c_dual_source: cover property (o_dual_valid && i_dual_src_sel == 2'h2);
    c_blanked_pixel: cover property (adv && !i_blank_n && !i_sync_n);
endmodule : ipl_palette_pipe

// File: test/ipl_host_model.sv
// Host processor model that loads the palettes and the dual mask word.
`timescale 1ns/1ps
module ipl_host_model (
    input wire logic i_clk_sys,
    output logic [15:0] o_addr,
    output logic [23:0] o_data,
    output logic o_ch1_we_n,
    output logic o_dual_we_n,
    output logic o_mask_we_n
);
    // A released bus shows the inverse of its last value so stale data cannot pass.
    task automatic release_bus();
        o_ch1_we_n = 1'b1;
        o_dual_we_n = 1'b1;
        o_mask_we_n = 1'b1;
        o_addr = ~o_addr;
        o_data = ~o_data;
    endtask : release_bus

    // Kind 0 writes the channel palette, 1 the dual palette, 2 the dual mask.
    task automatic put(input logic [1:0] kind, input logic [15:0] a, input logic [23:0] d);
        @(posedge i_clk_sys);
        #1;
        o_addr = a;
        o_data = d;
        o_ch1_we_n = (kind != 2'h0);
        o_dual_we_n = (kind != 2'h1);
        o_mask_we_n = (kind != 2'h2);
        @(posedge i_clk_sys);
        #1;
        // Address and data stay one more cycle so the stored entry is read back.
        o_ch1_we_n = 1'b1;
        o_dual_we_n = 1'b1;
        o_mask_we_n = 1'b1;
        @(posedge i_clk_sys);
        #1;
        release_bus();
    endtask : put

    initial begin
        o_addr = 16'h0000;
        o_data = 24'h000000;
        release_bus();
    end
endmodule : ipl_host_model

// File: test/tb_ipl_palette_pipe.sv
// Self-checking bench for the palette lookup pipeline.
`timescale 1ns/1ps
module tb_ipl_palette_pipe;
    import ipl_pkg::*;
    logic i_clk_sys = 1'b0;
    logic rst = 1'b1, en = 1'b1, vld = 1'b1, gate_n = 1'b1, q1 = 1'b1, q2 = 1'b1;
    logic ca = 1'b0, cb = 1'b0, chr = 1'b0, blk = 1'b0, oe = 1'b0, clr_n = 1'b1;
    logic sync_n = 1'b1, blank_n = 1'b1, dready = 1'b1;
    logic [7:0] pa = 8'h00, pb = 8'h00, dm = 8'h00;
    logic [3:0] om = 4'h0;
    logic [1:0] sel = 2'h0;
    logic [15:0] m16, a2, haddr;
    logic [11:0] a1;
    logic [23:0] gfx = 24'h000000, imgb = 24'h000000, d1, d2, ec, ed, hdata;
    logic we1, wed, wem, pix_ready, sync_o, cur_o, dvalid;
    logic [7:0] red, green, blue;
    logic [23:0] drgb;
    int err_count = 0;
    int checks = 0;

    always #20 i_clk_sys = ~i_clk_sys;

    ipl_host_model host (.i_clk_sys(i_clk_sys), .o_addr(haddr), .o_data(hdata),
        .o_ch1_we_n(we1), .o_dual_we_n(wed), .o_mask_we_n(wem));

    ipl_palette_pipe uut (.i_clk_sys(i_clk_sys), .i_sys_rst(rst), .i_clk_en(en),
        .i_pix_valid(vld), .o_pix_ready(pix_ready), .i_img_a_pixel_bits(pa),
        .i_img_b_pixel_bits(pb), .i_cursor_bit_a(ca), .i_cursor_bit_b(cb),
        .i_char_pixel_bit(chr), .i_blink_bit(blk), .i_ch1_data_mask(dm),
        .i_ch1_overlay_mask(om), .i_panel_blank_ch1(q1), .i_panel_blank_ch2(q2),
        .i_visible_line_gate_n(gate_n), .i_host_palette_addr(haddr),
        .i_host_palette_data(hdata), .i_ch1_palette_we_n(we1), .i_dual_palette_we_n(wed),
        .i_dual_mask_we_n(wem), .i_gfx_rgb(gfx), .i_img_b_rgb(imgb),
        .i_graphics_reg_clear_n(clr_n), .i_ch1_gfx_oe(oe), .i_dual_src_sel(sel),
        .i_sync_n(sync_n), .i_blank_n(blank_n), .o_ch1_red(red), .o_ch1_green(green),
        .o_ch1_blue(blue), .o_ch1_sync_n(sync_o), .o_sync_current_on(cur_o),
        .o_dual_valid(dvalid), .i_dual_ready(dready), .o_dual_rgb(drgb));

    function automatic logic [11:0] ch1_addr(input logic [3:0] ovl, input logic [7:0] px,
            input logic [7:0] dmask, input logic [3:0] omask, input logic q);
        return {ovl & omask, px & dmask & {8{q}}};
    endfunction : ch1_addr

    function automatic logic [15:0] dual_addr(input logic [7:0] a, input logic [7:0] b,
            input logic [15:0] m, input logic qa, input logic qb);
        return {b & m[15:8] & {8{qb}}, a & m[7:0] & {8{qa}}};
    endfunction : dual_addr

    task automatic step(input int n);
        repeat (n) @(posedge i_clk_sys);
        #1;
    endtask : step

    task automatic check(input logic [23:0] seen, input logic [23:0] exp, input string what);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : finish_test

    initial begin
        #800000;
        err_count++;
        finish_test();
    end

    initial begin
        void'($urandom(94611));
        step(16);
        check({blue, green, red}, 24'h000000, "reset colour");
        check(dvalid, 1'b0, "reset valid");
        rst = 1'b0;
        for (int i = 0; i < 16; i++) begin
            m16 = (i == 0) ? 16'hFFFF : 16'($urandom);
            dm = (i == 0) ? 8'hFF : 8'($urandom);
            om = (i == 0) ? 4'hF : 4'($urandom);
            pa = 8'($urandom);
            pb = 8'($urandom);
            {blk, chr, cb, ca} = 4'($urandom);
            q1 = (i == 1) ? 1'b0 : ($urandom % 4 != 0);
            q2 = (i == 1) ? 1'b0 : ($urandom % 4 != 0);
            oe = (i % 4 == 1);
            blank_n = (i % 4 < 2);
            sync_n = (i % 2 == 0);
            clr_n = !(i == 1 || i == 5);
            sel = 2'(i / 4);
            gfx = 24'($urandom);
            imgb = 24'($urandom);
            d1 = 24'($urandom);
            d2 = 24'($urandom);
            a1 = ch1_addr({blk, chr, cb, ca}, pa, dm, om, q1);
            a2 = dual_addr(pa, pb, m16, q1, q2);
            gate_n = 1'b1;
            host.put(2'h2, 16'h0000, {8'h00, m16});
            host.put(2'h0, {4'h0, a1}, d1);
            host.put(2'h1, a2, d2);
            gate_n = 1'b0;
            step(8);
            ec = !blank_n ? {3{IPL_BLANK_LEVEL}} : (oe ? (clr_n ? gfx : 24'h000000) : d1);
            ed = (sel == 2'h0) ? (clr_n ? gfx : 24'h000000) : (sel == 2'h1) ? d1 :
                (sel == 2'h3) ? imgb : d2;
            check({blue, green, red}, ec, "ch1 colour");
            check({sync_o, cur_o}, {2{!(!sync_n && !blank_n)}}, "sync");
            check(drgb, ed, "dual word");
            if (sel == 2'h2) begin
                host.put(2'h1, a2, ~d2);
                step(8);
                check(drgb, d2, "visible write");
            end
            $display("test %0d done", i);
        end
        dready = 1'b0;
        for (int k = 0; k < 10 && pix_ready !== 1'b0; k++) step(1);
        check(pix_ready, 1'b0, "full stall");
        check(dvalid, 1'b1, "held valid");
        check(drgb, ed, "held word");
        vld = 1'b0;
        dready = 1'b1;
        for (int k = 0; k < 10 && dvalid !== 1'b0; k++) step(1);
        check(dvalid, 1'b0, "drained");
        en = 1'b0;
        step(1);
        check(pix_ready, 1'b0, "enable low");
        $display("test buffer done");
        finish_test();
    end
endmodule : tb_ipl_palette_pipe
